// ===== hdl/instruction_fetch_sampler.sv
// fetch and op sampler with an AXI4-Lite register slave
// assumes the pipeline flags the tagged fetch/op on dedicated inputs
// Operation
// - count completed fetches while enabled, never aborted ones
// - at maximum, tag the next attempted fetch and watch it to its end
// - raise the fetch interrupt when the tagged fetch completes or aborts
// - periodic fetch counter and maximum fetch count are 20 bits
// - only the top 16 maximum bits are writable, low 4 read zero
// - periodic fetch counter clears when it reaches the maximum
// - software may load any value, including random low bits, into the counter
// - the virtual address of the tagged fetch is always reported
// - physical address valid only when address and page size are valid
// - separate first-attempt miss flags for L1, L2 translation and icache
// - completion flag only when the bytes reached the decoders
// - latency counts cycles from fetch start to delivery or abort
// - two-bit page size of the L1 translation used
// - fetch and op sampling have separate enables and registers
// - op counter counts cycles or dispatched ops, as software selects
// - at op maximum, tag an op and interrupt when it retires
// - periodic op counter is 27 bits, readable and writable
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "sampler_map.svh"
module instruction_fetch_sampler #(
    parameter int LAT_W = 16
) (
    // clock and reset
    input  wire logic                      mclk_i,
    input  wire logic                      rst_n_i,
    // register bus
    input  wire logic                      s_axi_awvalid_i,
    output logic                           s_axi_awready_o,
    input  wire logic [7:0]                s_axi_awaddr_i,
    input  wire logic                      s_axi_wvalid_i,
    output logic                           s_axi_wready_o,
    input  wire logic [31:0]               s_axi_wdata_i,
    input  wire logic [3:0]                s_axi_wstrb_i,
    output logic                           s_axi_bvalid_o,
    input  wire logic                      s_axi_bready_i,
    output logic [1:0]                     s_axi_bresp_o,
    input  wire logic                      s_axi_arvalid_i,
    output logic                           s_axi_arready_o,
    input  wire logic [7:0]                s_axi_araddr_i,
    output logic                           s_axi_rvalid_o,
    input  wire logic                      s_axi_rready_i,
    output logic [31:0]                    s_axi_rdata_o,
    output logic [1:0]                     s_axi_rresp_o,
    // fetch pipeline
    input  wire logic                      fetch_start_i,
    input  wire logic [31:0]               fetch_vaddr_i,
    input  wire logic                      fetch_complete_i,
    output logic                           tag_fetch_o,
    input  wire sampler_pkg::fetch_evt_t   tag_evt_i,
    input  wire logic                      tag_done_i,
    input  wire logic                      tag_abort_i,
    output logic                           fetch_irq_o,
    // op pipeline
    input  wire logic                      op_dispatch_i,
    input  wire logic [31:0]               op_addr_i,
    output logic                           tag_op_o,
    input  wire logic                      op_retire_i,
    input  wire logic                      op_flush_i,
    output logic                           op_irq_o
);
    if (LAT_W < 2 || LAT_W > 32) begin : g_chk
        $error("LAT_W must be 2..32");
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // bus slave: address and data taken in either order
    logic        awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d, rword;
    logic [3:0]  ws_q, ws_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;
    logic        wr_go, hit_w, hit_r;

    assign wr_go = !awr_q && !wr_q && !bv_q;

    always_comb begin
        awr_d = awr_q;
        wr_d  = wr_q;
        bv_d  = bv_q;
        awa_d = awa_q;
        wd_d  = wd_q;
        ws_d  = ws_q;
        br_d  = br_q;
        if (awr_q && s_axi_awvalid_i) begin
            awr_d = 1'b0;
            awa_d = s_axi_awaddr_i;
        end
        if (wr_q && s_axi_wvalid_i) begin
            wr_d = 1'b0;
            wd_d = s_axi_wdata_i;
            ws_d = s_axi_wstrb_i;
        end
        if (wr_go) begin
            bv_d = 1'b1;
            br_d = hit_w ? `SMP_RESP_OK : `SMP_RESP_ERR;
        end
        if (bv_q && s_axi_bready_i) begin
            bv_d  = 1'b0;
            awr_d = 1'b1;
            wr_d  = 1'b1;
        end
        arr_d = arr_q;
        rv_d  = rv_q;
        rd_d  = rd_q;
        rr_d  = rr_q;
        if (arr_q && s_axi_arvalid_i) begin
            arr_d = 1'b0;
            rv_d  = 1'b1;
            rd_d  = rword;
            rr_d  = hit_r ? `SMP_RESP_OK : `SMP_RESP_ERR;
        end else if (rv_q && s_axi_rready_i) begin
            rv_d  = 1'b0;
            arr_d = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            awr_q <= 1'b1;
            wr_q  <= 1'b1;
            bv_q  <= 1'b0;
            awa_q <= 8'h00;
            wd_q  <= 32'h0000_0000;
            ws_q  <= 4'h0;
            br_q  <= `SMP_RESP_OK;
            arr_q <= 1'b1;
            rv_q  <= 1'b0;
            rd_q  <= 32'h0000_0000;
            rr_q  <= `SMP_RESP_OK;
        end else begin
            awr_q <= awr_d;
            wr_q  <= wr_d;
            bv_q  <= bv_d;
            awa_q <= awa_d;
            wd_q  <= wd_d;
            ws_q  <= ws_d;
            br_q  <= br_d;
            arr_q <= arr_d;
            rv_q  <= rv_d;
            rd_q  <= rd_d;
            rr_q  <= rr_d;
        end
    end

    // fetch sampler state
    sampler_pkg::smp_state_t   fst_q, fst_d;
    sampler_pkg::fetch_flags_t ff_q, ff_d;
    logic              fen_q, fen_d;
    logic [15:0]       fmax_q, fmax_d;
    logic [19:0]       fcnt_q, fcnt_d, fmax;
    logic [LAT_W-1:0]  flat_q, flat_d;
    logic [31:0]       fva_q, fva_d, fpa_q, fpa_d;
    logic              wf_ctl, wf_cnt, f_end;
    logic [31:0]       fctl_rd, fctl_wr, fcnt_wr;

    // low four bits of the maximum are hard zero
    // low bits forced
    assign fmax    = {fmax_q, 4'h0};
    assign wf_ctl  = wr_go && awa_q == `SMP_A_FCTL;
    assign wf_cnt  = wr_go && awa_q == `SMP_A_FCNT;
    assign f_end   = tag_done_i || tag_abort_i;
    assign fctl_rd = {7'h00, ff_q, fst_q[`SMP_ST_DONE], fen_q, fmax_q};
    assign fctl_wr = merge(fctl_rd, wd_q, ws_q);
    assign fcnt_wr = merge({12'h000, fcnt_q}, wd_q, ws_q);

    always_comb begin
        fst_d  = fst_q;
        ff_d   = ff_q;
        fen_d  = fen_q;
        fmax_d = fmax_q;
        fcnt_d = fcnt_q;
        flat_d = flat_q;
        fva_d  = fva_q;
        fpa_d  = fpa_q;
        case (fst_q)
            sampler_pkg::S_IDLE: begin
                if (fen_q) begin
                    fst_d = sampler_pkg::S_COUNT;
                end
            end
            sampler_pkg::S_COUNT: begin
                if (!fen_q) begin
                    fst_d = sampler_pkg::S_IDLE;
                end else if (fetch_complete_i) begin
                    if (fcnt_q + 20'h0_0001 == fmax) begin
                        fcnt_d = 20'h0_0000;
                        fst_d  = sampler_pkg::S_ARMED;
                    end else begin
                        fcnt_d = fcnt_q + 20'h0_0001;
                    end
                end
            end
            sampler_pkg::S_ARMED: begin
                if (!fen_q) begin
                    fst_d = sampler_pkg::S_IDLE;
                end else if (fetch_start_i) begin
                    fva_d  = fetch_vaddr_i;
                    ff_d   = '0;
                    flat_d = '0;
                    fst_d  = sampler_pkg::S_TRACK;
                end
            end
            sampler_pkg::S_TRACK: begin
                if (flat_q != '1) begin
                    flat_d = flat_q + LAT_W'(1);
                end
                ff_d.l1_xlate_miss     = ff_q.l1_xlate_miss | tag_evt_i.l1_xlate_miss;
                ff_d.l2_xlate_miss     = ff_q.l2_xlate_miss | tag_evt_i.l2_xlate_miss;
                ff_d.icache_first_miss = ff_q.icache_first_miss | tag_evt_i.icache_first_miss;
                if (tag_evt_i.xlate_ok && !ff_q.phys_addr_valid) begin
                    ff_d.phys_addr_valid    = 1'b1;
                    ff_d.l1_xlate_page_size = tag_evt_i.l1_xlate_page_size;
                    fpa_d                   = tag_evt_i.paddr;
                end
                if (f_end) begin
                    ff_d.fetch_completed = tag_done_i;
                    fen_d                = 1'b0;
                    fst_d                = sampler_pkg::S_DONE;
                end
            end
            sampler_pkg::S_DONE: begin
                fst_d = sampler_pkg::S_DONE;
            end
            default: begin
                fst_d = sampler_pkg::S_IDLE;
            end
        endcase
        // only a control register write leaves the finished state, to counting if enabled, else to idle
        if (wf_ctl && !(fst_q == sampler_pkg::S_TRACK && f_end)) begin
            fmax_d = fctl_wr[15:0];
            fen_d  = fctl_wr[`SMP_FCTL_EN];
            if (!fctl_wr[`SMP_FCTL_EN]) begin
                fst_d = sampler_pkg::S_IDLE;
            end else if (fst_q == sampler_pkg::S_DONE || fst_q == sampler_pkg::S_IDLE) begin
                fst_d = sampler_pkg::S_COUNT;
            end
        end
        if (wf_cnt) begin
            fcnt_d = fcnt_wr[19:0];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fst_q  <= sampler_pkg::S_IDLE;
            ff_q   <= '0;
            fen_q  <= 1'b0;
            fmax_q <= 16'h0000;
            fcnt_q <= 20'h0_0000;
            flat_q <= '0;
            fva_q  <= 32'h0000_0000;
            fpa_q  <= 32'h0000_0000;
        end else begin
            fst_q  <= fst_d;
            ff_q   <= ff_d;
            fen_q  <= fen_d;
            fmax_q <= fmax_d;
            fcnt_q <= fcnt_d;
            flat_q <= flat_d;
            fva_q  <= fva_d;
            fpa_q  <= fpa_d;
        end
    end

    // op sampler: own enable and registers
    sampler_pkg::smp_state_t ost_q, ost_d;
    logic              oen_q, oen_d, omd_q, omd_d;
    logic [22:0]       omax_q, omax_d;
    logic [26:0]       ocnt_q, ocnt_d;
    logic [LAT_W-1:0]  olat_q, olat_d;
    logic [31:0]       oad_q, oad_d, octl_rd, octl_wr, ocnt_wr;
    logic [3:0]        lfsr_q, lfsr_d;
    logic              wo_ctl, wo_cnt, o_inc;

    assign wo_ctl  = wr_go && awa_q == `SMP_A_OCTL;
    assign wo_cnt  = wr_go && awa_q == `SMP_A_OCNT;
    assign octl_rd = {6'h00, ost_q[`SMP_ST_DONE], omd_q, oen_q, omax_q};
    assign octl_wr = merge(octl_rd, wd_q, ws_q);
    assign ocnt_wr = merge({5'h00, ocnt_q}, wd_q, ws_q);
    assign o_inc   = omd_q ? op_dispatch_i : 1'b1;

    always_comb begin
        ost_d  = ost_q;
        oen_d  = oen_q;
        omd_d  = omd_q;
        omax_d = omax_q;
        ocnt_d = ocnt_q;
        olat_d = olat_q;
        oad_d  = oad_q;
        lfsr_d = {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
        case (ost_q)
            sampler_pkg::S_IDLE: begin
                if (oen_q) begin
                    ost_d = sampler_pkg::S_COUNT;
                end
            end
            sampler_pkg::S_COUNT: begin
                if (!oen_q) begin
                    ost_d = sampler_pkg::S_IDLE;
                end else if (o_inc) begin
                    if (ocnt_q + 27'h000_0001 == {omax_q, 4'h0}) begin
                        ocnt_d = 27'h000_0000;
                        ost_d  = sampler_pkg::S_ARMED;
                    end else begin
                        ocnt_d = ocnt_q + 27'h000_0001;
                    end
                end
            end
            sampler_pkg::S_ARMED: begin
                if (!oen_q) begin
                    ost_d = sampler_pkg::S_IDLE;
                end else if (op_dispatch_i) begin
                    oad_d  = op_addr_i;
                    olat_d = '0;
                    ost_d  = sampler_pkg::S_TRACK;
                end
            end
            sampler_pkg::S_TRACK: begin
                if (olat_q != '1) begin
                    olat_d = olat_q + LAT_W'(1);
                end
                // flushed op drops the sample and restarts from a random count
                if (op_flush_i) begin
                    ocnt_d = {23'h00_0000, lfsr_q};
                    ost_d  = sampler_pkg::S_COUNT;
                end else if (op_retire_i) begin
                    oen_d = 1'b0;
                    ost_d = sampler_pkg::S_DONE;
                end
            end
            sampler_pkg::S_DONE: begin
                ost_d = sampler_pkg::S_DONE;
            end
            default: begin
                ost_d = sampler_pkg::S_IDLE;
            end
        endcase
        if (wo_ctl && !(ost_q == sampler_pkg::S_TRACK && op_retire_i)) begin
            omax_d = octl_wr[22:0];
            oen_d  = octl_wr[`SMP_OCTL_EN];
            omd_d  = octl_wr[`SMP_OCTL_MD];
            if (!octl_wr[`SMP_OCTL_EN]) begin
                ost_d = sampler_pkg::S_IDLE;
            end else if (ost_q == sampler_pkg::S_DONE || ost_q == sampler_pkg::S_IDLE) begin
                ost_d = sampler_pkg::S_COUNT;
            end
        end
        if (wo_cnt) begin
            ocnt_d = ocnt_wr[26:0];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ost_q  <= sampler_pkg::S_IDLE;
            oen_q  <= 1'b0;
            omd_q  <= 1'b0;
            omax_q <= 23'h00_0000;
            ocnt_q <= 27'h000_0000;
            olat_q <= '0;
            oad_q  <= 32'h0000_0000;
            lfsr_q <= `SMP_LFSR_RST;
        end else begin
            ost_q  <= ost_d;
            oen_q  <= oen_d;
            omd_q  <= omd_d;
            omax_q <= omax_d;
            ocnt_q <= ocnt_d;
            olat_q <= olat_d;
            oad_q  <= oad_d;
            lfsr_q <= lfsr_d;
        end
    end

    // read and write decode
    always_comb begin
        hit_w = awa_q == `SMP_A_FCTL || awa_q == `SMP_A_FCNT ||
                awa_q == `SMP_A_OCTL || awa_q == `SMP_A_OCNT;
        hit_r = 1'b1;
        rword = 32'h0000_0000;
        if (s_axi_araddr_i == `SMP_A_FCTL) begin
            rword = fctl_rd;
        end else if (s_axi_araddr_i == `SMP_A_FCNT) begin
            rword = {12'h000, fcnt_q};
        end else if (s_axi_araddr_i == `SMP_A_FLAT) begin
            rword = 32'(flat_q);
        end else if (s_axi_araddr_i == `SMP_A_FVA) begin
            rword = fva_q;
        end else if (s_axi_araddr_i == `SMP_A_FPA) begin
            rword = fpa_q;
        end else if (s_axi_araddr_i == `SMP_A_OCTL) begin
            rword = octl_rd;
        end else if (s_axi_araddr_i == `SMP_A_OCNT) begin
            rword = {5'h00, ocnt_q};
        end else if (s_axi_araddr_i == `SMP_A_OLAT) begin
            rword = 32'(olat_q);
        end else if (s_axi_araddr_i == `SMP_A_OADR) begin
            rword = oad_q;
        end else begin
            hit_r = 1'b0;
        end
    end

    assign s_axi_awready_o = awr_q;
    assign s_axi_wready_o  = wr_q;
    assign s_axi_bvalid_o  = bv_q;
    assign s_axi_bresp_o   = br_q;
    assign s_axi_arready_o = arr_q;
    assign s_axi_rvalid_o  = rv_q;
    assign s_axi_rdata_o   = rd_q;
    assign s_axi_rresp_o   = rr_q;
    assign tag_fetch_o     = fst_q[`SMP_ST_ARMED];
    assign fetch_irq_o     = fst_q[`SMP_ST_DONE];
    assign tag_op_o        = ost_q[`SMP_ST_ARMED];
    assign op_irq_o        = ost_q[`SMP_ST_DONE];

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_fstart;
        fst_q == sampler_pkg::S_ARMED && fen_q && fetch_start_i && !wf_ctl;
    endsequence
    sequence s_frun;
        fst_q == sampler_pkg::S_TRACK && !f_end && !wf_ctl;
    endsequence
    property p_fwrap;
        fst_q == sampler_pkg::S_COUNT && fen_q && fetch_complete_i &&
        fcnt_q + 20'h0_0001 == fmax && !wf_ctl && !wf_cnt
        |=> fst_q == sampler_pkg::S_ARMED && fcnt_q == 20'h0_0000 && tag_fetch_o;
    endproperty
    a_fwrap: assert property (p_fwrap) else $error("fetch wrap wrong");
    property p_fhold;
        fst_q == sampler_pkg::S_COUNT && !fetch_complete_i && !wf_cnt |=> $stable(fcnt_q);
    endproperty
    a_fhold: assert property (p_fhold) else $error("count moved");
    property p_firq;
        fst_q == sampler_pkg::S_TRACK && f_end |=> fetch_irq_o && !fen_q;
    endproperty
    a_firq: assert property (p_firq) else $error("no fetch irq");
    property p_fabort;
        fst_q == sampler_pkg::S_TRACK && tag_abort_i && !tag_done_i
        |=> !ff_q.fetch_completed;
    endproperty
    a_fabort: assert property (p_fabort) else $error("abort marked done");
    property p_flat;
        s_fstart ##1 s_frun [*3] |=> flat_q == LAT_W'(3);
    endproperty
    a_flat: assert property (p_flat) else $error("latency off");
    property p_fva;
        s_fstart |=> fva_q == $past(fetch_vaddr_i) && fst_q == sampler_pkg::S_TRACK;
    endproperty
    a_fva: assert property (p_fva) else $error("vaddr lost");
    property p_fpav;
        $rose(ff_q.phys_addr_valid) |-> $past(tag_evt_i.xlate_ok);
    endproperty
    a_fpav: assert property (p_fpav) else $error("pav without xlate");
    property p_fkeep;
        fetch_irq_o && !wf_ctl |=> fetch_irq_o && $stable(fva_q) && $stable(ff_q);
    endproperty
    a_fkeep: assert property (p_fkeep) else $error("sample not held");
    property p_ocyc;
        ost_q == sampler_pkg::S_COUNT && oen_q && !omd_q && !wo_ctl && !wo_cnt &&
        ocnt_q + 27'h000_0001 != {omax_q, 4'h0} |=> ocnt_q == $past(ocnt_q) + 27'h000_0001;
    endproperty
    a_ocyc: assert property (p_ocyc) else $error("op count off");
    property p_oirq;
        ost_q == sampler_pkg::S_TRACK && op_retire_i && !op_flush_i |=> op_irq_o;
    endproperty
    a_oirq: assert property (p_oirq) else $error("no op irq");
endmodule

// ===== hdl/sampler_map.svh
// register map, field positions and reset values of the fetch/op sampler
// assumes a 32-bit register bus with byte addressing
`ifndef SAMPLER_MAP_SVH
`define SAMPLER_MAP_SVH
`define SMP_A_FCTL   8'h00
`define SMP_A_FCNT   8'h04
`define SMP_A_FLAT   8'h08
`define SMP_A_FVA    8'h0C
`define SMP_A_FPA    8'h10
`define SMP_A_OCTL   8'h14
`define SMP_A_OCNT   8'h18
`define SMP_A_OLAT   8'h1C
`define SMP_A_OADR   8'h20
`define SMP_FCTL_EN  16
`define SMP_OCTL_EN  23
`define SMP_OCTL_MD  24
`define SMP_ST_ARMED 2
`define SMP_ST_DONE  4
`define SMP_LFSR_RST 4'h1
`define SMP_RESP_OK  2'h0
`define SMP_RESP_ERR 2'h2
`endif

// ===== hdl/sampler_pkg.sv
// types shared by the fetch/op sampler
// no constants here; the map header carries them
package sampler_pkg;
    typedef enum logic [4:0] {
        S_IDLE  = 5'h01,
        S_COUNT = 5'h02,
        S_ARMED = 5'h04,
        S_TRACK = 5'h08,
        S_DONE  = 5'h10
    } smp_state_t;
    // events of the tagged fetch, each a one-cycle pulse
    typedef struct packed {
        logic        l1_xlate_miss;
        logic        l2_xlate_miss;
        logic        icache_first_miss;
        logic        xlate_ok;
        logic [1:0]  l1_xlate_page_size;
        logic [31:0] paddr;
    } fetch_evt_t;
    typedef struct packed {
        logic       fetch_completed;
        logic       icache_first_miss;
        logic       l1_xlate_miss;
        logic       l2_xlate_miss;
        logic       phys_addr_valid;
        logic [1:0] l1_xlate_page_size;
    } fetch_flags_t;
endpackage

// ===== sim/fetch_pipe_model.sv
// pipeline model for the sampler's far side: tagged fetch and tagged op
// assumes tag levels from the sampler and answers with one-cycle pulses
`timescale 1ns/100ps
module fetch_pipe_model (
    input  wire logic               mclk_i, tag_fetch_i, tag_op_i, abort_i,
    input  wire logic [7:0]         lat_i,
    output sampler_pkg::fetch_evt_t tag_evt_o,
    output logic [31:0]             fetch_vaddr_o, op_addr_o,
    output logic                    fetch_start_o, tag_done_o, tag_abort_o,
    output logic                    op_dispatch_o, op_retire_o
);
    initial {tag_evt_o, fetch_vaddr_o, op_addr_o, fetch_start_o, tag_done_o, tag_abort_o,
             op_dispatch_o, op_retire_o} = '0;
    always begin
        @(posedge mclk_i);
        if (tag_fetch_i === 1'b1) begin
            {fetch_start_o, fetch_vaddr_o} <= {1'b1, 32'h0040_1230};
            @(posedge mclk_i);
            // released lines carry the inverse so a stale value never matches
            {fetch_start_o, fetch_vaddr_o} <= {1'b0, 32'hffbf_edcf};
            tag_evt_o <= {4'b1001, 2'h2, 32'h0800_1230};
            @(posedge mclk_i);
            tag_evt_o <= {4'b0000, 2'h1, 32'hf7ff_edcf};
            repeat (lat_i - 2) @(posedge mclk_i);
            {tag_abort_o, tag_done_o} <= {abort_i, ~abort_i};
            @(posedge mclk_i);
            {tag_abort_o, tag_done_o} <= 2'b00;
        end
    end
    always begin
        @(posedge mclk_i);
        if (tag_op_i === 1'b1) begin
            {op_dispatch_o, op_addr_o} <= {1'b1, 32'h0040_2000};
            @(posedge mclk_i);
            {op_dispatch_o, op_addr_o} <= {1'b0, 32'hffbf_dfff};
            repeat (3) @(posedge mclk_i);
            op_retire_o <= 1'b1;
            @(posedge mclk_i);
            op_retire_o <= 1'b0;
        end
    end
endmodule

// ===== sim/instruction_fetch_sampler_bench.sv
// bench for the sampler: bus tasks and checked sequences of calls
// assumes the map header offsets and the pipeline model on the far side
`timescale 1ns/100ps
`include "sampler_map.svh"
module instruction_fetch_sampler_bench;
    logic        mclk_i, rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i, abort;
    logic        s_axi_bready_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
    logic        s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, fetch_start_i;
    logic        fetch_complete_i, tag_fetch_o, tag_done_i, tag_abort_i, fetch_irq_o;
    logic        op_dispatch_i, tag_op_o, op_retire_i, op_irq_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rsp;
    logic [3:0]  s_axi_wstrb_i;
    logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i, lat;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, fetch_vaddr_i, op_addr_i;
    sampler_pkg::fetch_evt_t tag_evt_i;
    int          miscompares = 0, n_tests = 0, cyc = 0;
    instruction_fetch_sampler dut_u (.mclk_i, .rst_n_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_awaddr_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
        .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o,
        .s_axi_araddr_i, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .s_axi_rresp_o,
        .fetch_start_i, .fetch_vaddr_i, .fetch_complete_i, .tag_fetch_o, .tag_evt_i,
        .tag_done_i, .tag_abort_i, .fetch_irq_o, .op_dispatch_i, .op_addr_i, .tag_op_o,
        .op_retire_i, .op_flush_i(1'b0), .op_irq_o);
    fetch_pipe_model pipe_u (.mclk_i, .tag_fetch_i(tag_fetch_o), .tag_op_i(tag_op_o),
        .abort_i(abort), .lat_i(lat), .tag_evt_o(tag_evt_i), .fetch_vaddr_o(fetch_vaddr_i),
        .op_addr_o(op_addr_i), .fetch_start_o(fetch_start_i), .tag_done_o(tag_done_i),
        .tag_abort_o(tag_abort_i), .op_dispatch_o(op_dispatch_i), .op_retire_o(op_retire_i));
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        if (++cyc == 5000) begin
            miscompares = miscompares + 1;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // address and data may be taken on different edges
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ap = 1'b1, wp = 1'b1;
        {s_axi_awvalid_i, s_axi_wvalid_i} <= 2'b11;
        {s_axi_awaddr_i, s_axi_wdata_i} <= {a, d};
        while (ap || wp) begin
            @(posedge mclk_i);
            ap = ap && (s_axi_awready_o !== 1'b1);
            wp = wp && (s_axi_wready_o !== 1'b1);
            {s_axi_awvalid_i, s_axi_wvalid_i} <= {ap, wp};
        end
        do @(posedge mclk_i); while (s_axi_bvalid_o !== 1'b1);
        rsp = s_axi_bresp_o;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        {s_axi_arvalid_i, s_axi_araddr_i} <= {1'b1, a};
        do @(posedge mclk_i); while (s_axi_arready_o !== 1'b1);
        s_axi_arvalid_i <= 1'b0;
        do @(posedge mclk_i); while (s_axi_rvalid_o !== 1'b1);
        rsp = s_axi_rresp_o;
        chk(nm, s_axi_rdata_o, e);
    endtask
    task automatic sample(input logic ab, input logic [7:0] lt, input logic [31:0] ctl);
        {abort, lat} <= {ab, lt};
        wr(`SMP_A_FCNT, 32'h0000_000d);
        wr(`SMP_A_FCTL, 32'h0001_0001);
        chk("wr_resp", 32'(rsp), 32'h0);
        chk("irq_rearm", 32'(fetch_irq_o), 32'h0);
        repeat (3) begin
            chk("tag_early", 32'(tag_fetch_o), 32'h0);
            fetch_complete_i <= 1'b1;
            @(posedge mclk_i);
            fetch_complete_i <= 1'b0;
            @(posedge mclk_i);
        end
        @(posedge mclk_i);
        chk("tag_armed", 32'(tag_fetch_o), 32'h1);
        rdc(`SMP_A_FCNT, 32'h0, "fcnt_clear");
        do @(posedge mclk_i); while (fetch_irq_o !== 1'b1);
        rdc(`SMP_A_FCTL, ctl, "fctl_flags");
        rdc(`SMP_A_FLAT, {24'h0, lt}, "latency");
        rdc(`SMP_A_FVA, 32'h0040_1230, "vaddr");
        rdc(`SMP_A_FPA, 32'h0800_1230, "paddr");
    endtask
    initial begin
        {rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i, abort} = '0;
        {fetch_complete_i, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, lat} = '0;
        {s_axi_bready_i, s_axi_rready_i, s_axi_wstrb_i} = 6'h3f;
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        wr(`SMP_A_FCNT, 32'hffff_ffff);
        rdc(`SMP_A_FCNT, 32'h000f_ffff, "fcnt_width");
        wr(`SMP_A_OCNT, 32'hffff_ffff);
        rdc(`SMP_A_OCNT, 32'h07ff_ffff, "ocnt_width");
        rdc(8'h40, 32'h0, "unmapped_data");
        chk("unmapped_resp", 32'(rsp), 32'h2);
        wr(`SMP_A_FLAT, 32'h0000_0000);
        chk("ro_resp", 32'(rsp), 32'h2);
        wr(`SMP_A_OCNT, 32'h0);
        wr(`SMP_A_OCTL, 32'h0080_0001);
        sample(1'b0, 8'h06, 32'h015a_0001);
        rdc(`SMP_A_OADR, 32'h0040_2000, "op_addr");
        chk("op_irq", 32'(op_irq_o), 32'h1);
        rdc(`SMP_A_OLAT, 32'h0000_0004, "op_lat");
        // dispatch mode with no dispatches must not count cycles
        wr(`SMP_A_OCTL, 32'h0180_0001);
        rdc(`SMP_A_OCTL, 32'h0180_0001, "op_mode");
        sample(1'b1, 8'h04, 32'h005a_0001);
        rdc(`SMP_A_OCNT, 32'h0000_0000, "ocnt_dispatch");
        end_sim();
    end
endmodule
